/* hw/fofp_defines.svh */
/*
  Constants of the flag-offset programming block: geometry, offset
  defaults, flag validity latency and the register map of the bus slave.
  Assumes inclusion by bare name from files that need these values.
*/
`ifndef FOFP_DEFINES_SVH
`define FOFP_DEFINES_SVH

// Geometry
`define FOFP_DEPTH        131072
`define FOFP_OFS_W        17
`define FOFP_LO_W         9
`define FOFP_DATA_W       18

// Offset defaults chosen by the load select sampled at master reset
`define FOFP_DEF_PAR      17'h0007F
`define FOFP_DEF_SER      17'h003FF

// Write clock edges after completion before a partial flag is valid
`define FOFP_VALID_DLY    2

// Register map (byte addresses)
`define FOFP_CTRL_ADDR    4'h0
`define FOFP_STATUS_ADDR  4'h4
`define FOFP_COUNT_ADDR   4'h8
`define FOFP_CTRL_PRST    0

// Status field positions
`define FOFP_ST_SERIAL    0
`define FOFP_ST_FALL_THROUGH_MODE      1
`define FOFP_ST_EVALID    2
`define FOFP_ST_FVALID    3
`define FOFP_ST_FLAGS     4

// Bus responses
`define FOFP_RESP_OKAY    2'h0
`define FOFP_RESP_SLVERR  2'h2

`endif

/* hw/fofp_pkg.sv */
/*
  Types shared by the flag-offset programming block.
  Assumes fofp_defines.svh is on the include path.
*/
package fofp_pkg;
  // Which of the four offset register parts a pointer selects
  typedef logic [1:0] fofp_ptr_type;
  // Offset loading method, fixed at master reset
  typedef enum logic {FOFP_PARALLEL, FOFP_SERIAL} fofp_method_type;
  // AXI4-Lite response code
  typedef logic [1:0] fofp_resp_type;
endpackage

/* hw/fofp_flag_offset.sv */
/*
  Status flags and programmable flag offsets of a deep dual-port FIFO,
  with an AXI4-Lite slave for control and status. The memory itself is
  outside; only the fill level is tracked here.
  Assumes the port controller runs on clk_sys_i, so every one of its
  edges is a clk_sys_i edge and its pins need no synchroniser.

*/
`timescale 1ns/1ns
`include "fofp_defines.svh"

module fofp_flag_offset #(
  parameter int DEPTH = `FOFP_DEPTH,
  parameter int OFS_W = `FOFP_OFS_W,
  parameter int LO_W  = `FOFP_LO_W,
  parameter int DW    = `FOFP_DATA_W
) (
  // Clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_i,
  // Controller pins
  input  wire logic                    master_reset_n_i,
  input  wire logic                    partial_reset_n_i,
  input  wire logic                    offset_load_select_n_i,
  input  wire logic                    write_enable_n_i,
  input  wire logic                    read_enable_n_i,
  input  wire logic                    shift_enable_n_i,
  input  wire logic                    serial_offset_in_i,
  input  wire logic                    fall_through_mode_i,
  input  wire logic [DW-1:0]           data_inputs_i,
  // Data and flags
  output logic      [DW-1:0]           data_outputs_o,
  output logic                         full_flag_n_o,
  output logic                         empty_flag_n_o,
  output logic                         input_ready_n_o,
  output logic                         output_ready_n_o,
  output logic                         half_full_flag_n_o,
  output logic                         almost_full_flag_n_o,
  output logic                         almost_empty_flag_n_o,
  // AXI4-Lite slave
  input  wire logic [3:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output fofp_pkg::fofp_resp_type      s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [3:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic      [31:0]             s_axi_rdata,
  output fofp_pkg::fofp_resp_type      s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready
);
  import fofp_pkg::*;

  localparam int SER_W = 2 * OFS_W;
  localparam int HI_W  = OFS_W - LO_W;
  localparam int CNT_W = $clog2(DEPTH + 2);
  localparam int SC_W  = $clog2(SER_W);
  // Compare width holds count plus offset without wrapping
  localparam int CMP_W = (CNT_W > OFS_W ? CNT_W : OFS_W) + 1;

  if (OFS_W < $clog2(DEPTH) || LO_W > DW || HI_W > DW || HI_W < 1)
    $error("fofp_flag_offset: unsupported geometry");

  function automatic int part_base(input fofp_ptr_type p);
    case (p)
      2'h0:    part_base = 0;
      2'h1:    part_base = LO_W;
      2'h2:    part_base = OFS_W;
      default: part_base = OFS_W + LO_W;
    endcase
  endfunction

  function automatic int part_width(input fofp_ptr_type p);
    part_width = p[0] ? HI_W : LO_W;
  endfunction

  function automatic logic addr_ok(input logic [3:0] a);
    addr_ok = (a == `FOFP_CTRL_ADDR) || (a == `FOFP_STATUS_ADDR) ||
              (a == `FOFP_COUNT_ADDR);
  endfunction

  // Configuration, offsets and pointers
  fofp_method_type    method_reg, method_next;
  logic               fall_through_mode_reg, fall_through_mode_next;
  logic [SER_W-1:0]   ofs_reg, ofs_next;
  fofp_ptr_type       wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [SC_W-1:0]    ser_cnt_reg, ser_cnt_next;
  logic [1:0]         epipe_reg, epipe_next, fpipe_reg, fpipe_next;
  logic               evalid_reg, evalid_next, fvalid_reg, fvalid_next;
  // Fill level, data and flags
  logic [CNT_W-1:0]   cnt_reg, cnt_next;
  logic [DW-1:0]      dout_reg, dout_next;
  logic [6:0]         flags_reg, flags_next;
  // Bus slave
  logic               aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [3:0]         awaddr_reg, awaddr_next;
  logic [31:0]        wdata_reg, wdata_next;
  logic [3:0]         wstrb_reg, wstrb_next;
  logic               bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  fofp_resp_type      bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0]        rdata_reg, rdata_next;
  logic               prst_reg, prst_next;

  // Enable decode
  logic ofs_sel, par_wr, par_rd, ser_sh, mem_wr, mem_rd, mrst, prst;
  logic [OFS_W-1:0] empty_ofs, full_ofs;
  logic [CNT_W-1:0] cap;
  logic full_now, empty_now;
  logic e_clr, e_done, f_clr, f_done;

  assign ofs_sel = !offset_load_select_n_i;
  assign par_wr  = ofs_sel && !write_enable_n_i && read_enable_n_i &&
                   shift_enable_n_i && method_reg == FOFP_PARALLEL;
  assign par_rd  = ofs_sel && write_enable_n_i && !read_enable_n_i &&
                   shift_enable_n_i;
  assign ser_sh  = ofs_sel && write_enable_n_i && read_enable_n_i &&
                   !shift_enable_n_i && method_reg == FOFP_SERIAL;
  assign mrst    = !master_reset_n_i;
  // Software request acts as a partial reset one cycle after the write
  assign prst    = !partial_reset_n_i || prst_reg;
  assign empty_ofs = ofs_reg[OFS_W-1:0];
  assign full_ofs  = ofs_reg[SER_W-1:OFS_W];
  assign cap       = CNT_W'(DEPTH) + CNT_W'(fall_through_mode_reg);
  assign full_now  = cnt_reg == cap;
  assign empty_now = cnt_reg == '0;
  assign mem_wr    = offset_load_select_n_i && !write_enable_n_i &&
                     !full_now;
  assign mem_rd    = offset_load_select_n_i && !read_enable_n_i &&
                     !empty_now;

  // Validity triggers; a parallel write to a flag's low part restarts it
  always_comb begin
    e_clr  = 1'b0;
    e_done = 1'b0;
    f_clr  = 1'b0;
    f_done = 1'b0;
    if (ser_sh) begin
      e_clr  = ser_cnt_reg == '0;
      f_clr  = ser_cnt_reg == '0;
      e_done = ser_cnt_reg == SC_W'(SER_W - 1);
      f_done = ser_cnt_reg == SC_W'(SER_W - 1);
    end else if (par_wr) begin
      e_clr  = wptr_reg == 2'h0;
      e_done = wptr_reg == 2'h1;
      f_clr  = wptr_reg == 2'h2;
      f_done = wptr_reg == 2'h3;
    end
  end

  // Configuration, offsets, pointers, validity
  always_comb begin
    method_next  = method_reg;
    fall_through_mode_next    = fall_through_mode_reg;
    ofs_next     = ofs_reg;
    wptr_next    = wptr_reg;
    rptr_next    = rptr_reg;
    ser_cnt_next = ser_cnt_reg;
    epipe_next   = {epipe_reg[0], e_done};
    fpipe_next   = {fpipe_reg[0], f_done};
    evalid_next  = (evalid_reg && !e_clr) || epipe_reg[1];
    fvalid_next  = (fvalid_reg && !f_clr) || fpipe_reg[1];
    if (mrst) begin
      method_next  = offset_load_select_n_i ? FOFP_SERIAL : FOFP_PARALLEL;
      fall_through_mode_next    = fall_through_mode_i;
      ofs_next     = offset_load_select_n_i ?
                     {2{OFS_W'(`FOFP_DEF_SER)}} :
                     {2{OFS_W'(`FOFP_DEF_PAR)}};
      wptr_next    = 2'h0;
      rptr_next    = 2'h0;
      ser_cnt_next = '0;
      epipe_next   = '0;
      fpipe_next   = '0;
      evalid_next  = 1'b1;
      fvalid_next  = 1'b1;
    end else begin
      if (ser_sh) begin
        ofs_next     = {serial_offset_in_i, ofs_reg[SER_W-1:1]};
        ser_cnt_next = e_done ? '0 : SC_W'(ser_cnt_reg + 1'b1);
      end
      if (par_wr) begin
        for (int b = 0; b < SER_W; b++) begin
          if (b >= part_base(wptr_reg) &&
              b < part_base(wptr_reg) + part_width(wptr_reg))
            ofs_next[b] = data_inputs_i[b - part_base(wptr_reg)];
        end
        wptr_next = fofp_ptr_type'(wptr_reg + 1'b1);
      end
      if (par_rd)
        rptr_next = fofp_ptr_type'(rptr_reg + 1'b1);
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      method_reg  <= FOFP_PARALLEL;
      fall_through_mode_reg    <= 1'b0;
      ofs_reg     <= {2{OFS_W'(`FOFP_DEF_PAR)}};
      wptr_reg    <= 2'h0;
      rptr_reg    <= 2'h0;
      ser_cnt_reg <= '0;
      epipe_reg   <= '0;
      fpipe_reg   <= '0;
      evalid_reg  <= 1'b1;
      fvalid_reg  <= 1'b1;
    end else begin
      method_reg  <= method_next;
      fall_through_mode_reg    <= fall_through_mode_next;
      ofs_reg     <= ofs_next;
      wptr_reg    <= wptr_next;
      rptr_reg    <= rptr_next;
      ser_cnt_reg <= ser_cnt_next;
      epipe_reg   <= epipe_next;
      fpipe_reg   <= fpipe_next;
      evalid_reg  <= evalid_next;
      fvalid_reg  <= fvalid_next;
    end
  end

  // Fill level, data outputs and flags. Flags lag the level by one edge.
  always_comb begin
    cnt_next  = cnt_reg;
    dout_next = dout_reg;
    if (mem_wr && !mem_rd)
      cnt_next = CNT_W'(cnt_reg + 1'b1);
    else if (mem_rd && !mem_wr)
      cnt_next = CNT_W'(cnt_reg - 1'b1);
    if (par_rd) begin
      dout_next = '0;
      for (int b = 0; b < DW; b++) begin
        if (b < part_width(rptr_reg))
          dout_next[b] = ofs_reg[part_base(rptr_reg) + b];
      end
    end
    if (mrst || prst) begin
      cnt_next  = '0;
      dout_next = '0;
    end
    // {full, empty, half, almost full, almost empty, in-ready, out-ready}
    flags_next[6] = !(!fall_through_mode_reg && full_now);
    flags_next[5] = !fall_through_mode_reg ? !empty_now : 1'b1;
    flags_next[4] = !(cnt_reg >= CNT_W'(DEPTH / 2 + 1) + CNT_W'(fall_through_mode_reg));
    flags_next[3] = !(fvalid_reg &&
                      CMP_W'(cnt_reg) + CMP_W'(full_ofs) >= CMP_W'(cap));
    flags_next[2] = evalid_reg ?
                    !(CMP_W'(cnt_reg) <=
                      CMP_W'(empty_ofs) + CMP_W'(fall_through_mode_reg)) :
                    1'b0;
    flags_next[1] = fall_through_mode_reg && full_now;
    flags_next[0] = fall_through_mode_reg ? empty_now : 1'b1;
    if (mrst || prst)
      flags_next = {1'b1, !fall_through_mode_next, 1'b1, 1'b1, 1'b0, 1'b0, fall_through_mode_next};
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg   <= '0;
      dout_reg  <= '0;
      flags_reg <= 7'h59;
    end else begin
      cnt_reg   <= cnt_next;
      dout_reg  <= dout_next;
      flags_reg <= flags_next;
    end
  end

  assign data_outputs_o        = dout_reg;
  assign full_flag_n_o         = flags_reg[6];
  assign empty_flag_n_o        = flags_reg[5];
  assign half_full_flag_n_o    = flags_reg[4];
  assign almost_full_flag_n_o  = flags_reg[3];
  assign almost_empty_flag_n_o = flags_reg[2];
  assign input_ready_n_o       = flags_reg[1];
  assign output_ready_n_o      = flags_reg[0];

  // Bus slave: address and data taken in either order, one write at a time
  always_comb begin
    aw_held_next = aw_held_reg || (s_axi_awvalid && s_axi_awready);
    w_held_next  = w_held_reg || (s_axi_wvalid && s_axi_wready);
    awaddr_next  = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr
                                                    : awaddr_reg;
    wdata_next   = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wdata_reg;
    wstrb_next   = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wstrb_reg;
    bvalid_next  = bvalid_reg && !s_axi_bready;
    bresp_next   = bresp_reg;
    prst_next    = 1'b0;
    if (aw_held_reg && w_held_reg && !bvalid_reg) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = addr_ok(awaddr_reg) ? `FOFP_RESP_OKAY
                                         : `FOFP_RESP_SLVERR;
      prst_next    = awaddr_reg == `FOFP_CTRL_ADDR && wstrb_reg[0] &&
                     wdata_reg[`FOFP_CTRL_PRST];
    end
    rvalid_next = rvalid_reg && !s_axi_rready;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = addr_ok(s_axi_araddr) ? `FOFP_RESP_OKAY
                                          : `FOFP_RESP_SLVERR;
      rdata_next  = '0;
      if (s_axi_araddr == `FOFP_STATUS_ADDR) begin
        rdata_next[`FOFP_ST_SERIAL] = method_reg == FOFP_SERIAL;
        rdata_next[`FOFP_ST_FALL_THROUGH_MODE]   = fall_through_mode_reg;
        rdata_next[`FOFP_ST_EVALID] = evalid_reg;
        rdata_next[`FOFP_ST_FVALID] = fvalid_reg;
        rdata_next[`FOFP_ST_FLAGS +: 7] = flags_reg;
      end else if (s_axi_araddr == `FOFP_COUNT_ADDR)
        rdata_next[CNT_W-1:0] = cnt_reg;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 4'h0;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `FOFP_RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= `FOFP_RESP_OKAY;
      prst_reg    <= 1'b0;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      prst_reg    <= prst_next;
    end
  end

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence ser_last_s;
    ser_sh && !mrst && ser_cnt_reg == SC_W'(SER_W - 1);
  endsequence
  sequence par_full_msb_s;
    par_wr && !mrst && wptr_reg == 2'h3;
  endsequence

  std_full_a: assert property (!fall_through_mode_reg && !mrst && !prst && full_now
    |=> !full_flag_n_o) else $error("full flag not low at depth");
  std_almost_a: assert property (!fall_through_mode_reg && fvalid_reg && !mrst &&
    !prst && CMP_W'(cnt_reg) + CMP_W'(full_ofs) >= CMP_W'(cap)
    |=> !almost_full_flag_n_o)
    else $error("almost full not low at depth minus m");
  fall_through_mode_ready_a: assert property (fall_through_mode_reg && !mrst && !prst &&
    cnt_reg == CNT_W'(DEPTH + 1) |=> input_ready_n_o)
    else $error("input ready not high when full");
  fall_through_mode_half_a: assert property (fall_through_mode_reg && !mrst && !prst &&
    cnt_reg >= CNT_W'(DEPTH / 2 + 2) |=> !half_full_flag_n_o)
    else $error("half full not low in fall-through");
  ofs_default_a: assert property (mrst |=> ofs_reg == ($past(
    offset_load_select_n_i) ? {2{OFS_W'(`FOFP_DEF_SER)}}
                            : {2{OFS_W'(`FOFP_DEF_PAR)}}))
    else $error("offset default wrong after master reset");
  ser_valid_a: assert property (ser_last_s |=> !fvalid_reg [*2]
    ##1 (fvalid_reg && evalid_reg))
    else $error("flags not valid two edges after serial load");
  par_wrap_a: assert property (par_full_msb_s |=> wptr_reg == 2'h0 &&
    fpipe_reg[0]) else $error("parallel write pointer did not wrap");
  ser_pause_a: assert property (!ser_sh && !mrst |=>
    $stable(ser_cnt_reg)) else $error("serial position moved while paused");
  ptr_keep_a: assert property (!mrst && !par_wr && !par_rd |=>
    $stable(wptr_reg) && $stable(rptr_reg))
    else $error("offset pointer moved without access");
  ofs_read_a: assert property (par_rd && !mrst && !prst |=>
    data_outputs_o[LO_W-1:0] == ($past(rptr_reg) == 2'h0 ?
    $past(ofs_reg[LO_W-1:0]) : data_outputs_o[LO_W-1:0]))
    else $error("offset read did not present empty LSB");
  method_lock_a: assert property (!mrst && $past(!mrst) |->
    $stable(method_reg)) else $error("method changed outside reset");

endmodule // fofp_flag_offset

/* verif/fofp_ctrl_model.sv */
/*
  Controller model that drives the write and read port pins.
  Assumes it shares clk_sys_i with the block; pins change after edges.
*/
`timescale 1ns/1ns
module fofp_ctrl_model (
  // Clock
  input  wire logic        clk_sys_i,
  // Port pins
  output logic             master_reset_n_o,
  output logic             partial_reset_n_o,
  output logic             offset_load_select_n_o,
  output logic             write_enable_n_o,
  output logic             read_enable_n_o,
  output logic             shift_enable_n_o,
  output logic             serial_offset_in_o,
  output logic             fall_through_mode_o,
  output logic [17:0]      data_inputs_o
);
  initial begin
    master_reset_n_o = 1'b1;
    partial_reset_n_o = 1'b1;
    {offset_load_select_n_o, write_enable_n_o} = 2'h3;
    {read_enable_n_o, shift_enable_n_o} = 2'h3;
    serial_offset_in_o = 1'b0;
    fall_through_mode_o = 1'b0;
    data_inputs_o = 18'h0;
  end
  // Method and timing mode are only looked at while reset is low
  task automatic mreset(input logic ser, input logic ft);
    @(posedge clk_sys_i);
    master_reset_n_o <= 1'b0;
    offset_load_select_n_o <= ser;
    fall_through_mode_o <= ft;
    repeat (2) @(posedge clk_sys_i);
    master_reset_n_o <= 1'b1;
    offset_load_select_n_o <= 1'b1;
    fall_through_mode_o <= ~ft;
  endtask
  // One request, one enable at a time, never read and write together
  task automatic op(input logic [3:0] c, input logic si,
                    input logic [17:0] d);
    @(posedge clk_sys_i);
    {offset_load_select_n_o, write_enable_n_o} <= c[3:2];
    {read_enable_n_o, shift_enable_n_o} <= c[1:0];
    serial_offset_in_o <= si;
    data_inputs_o <= d;
    @(posedge clk_sys_i);
    {offset_load_select_n_o, write_enable_n_o} <= 2'h3;
    {read_enable_n_o, shift_enable_n_o} <= 2'h3;
    // Released lines must not keep showing the last value
    serial_offset_in_o <= ~si;
    data_inputs_o <= ~d;
  endtask
  // One edge of partial reset; offsets and pointers must survive
  task automatic preset();
    @(posedge clk_sys_i);
    partial_reset_n_o <= 1'b0;
    @(posedge clk_sys_i);
    partial_reset_n_o <= 1'b1;
  endtask
endmodule // fofp_ctrl_model

/* verif/test_fofp_flag_offset.sv */
/*
  Bench of the flag-offset block: offset loading both ways, readback,
  flags over the fill range and the bus registers.
  Assumes the controller model shares clk_sys_i with the block.
*/
`timescale 1ns/1ns
`include "fofp_defines.svh"
module test_fofp_flag_offset;
  import fofp_pkg::*;
  // Short depth keeps full sweeps to a few thousand cycles
  localparam int D = 256;
  localparam logic [3:0] PWR = 4'h3, PRD = 4'h5, SHF = 4'h6;
  localparam logic [3:0] MWR = 4'hB, MRD = 4'hD, NOP = 4'h7;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic master_reset_n_i, partial_reset_n_i, offset_load_select_n_i;
  logic write_enable_n_i, read_enable_n_i, shift_enable_n_i;
  logic serial_offset_in_i, fall_through_mode_i;
  logic [17:0] data_inputs_i, data_outputs_o;
  logic full_flag_n_o, empty_flag_n_o, input_ready_n_o, output_ready_n_o;
  logic half_full_flag_n_o, almost_full_flag_n_o, almost_empty_flag_n_o;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  fofp_resp_type s_axi_bresp, s_axi_rresp, resp;
  int num_errors = 0;
  int comparisons = 0;
  int cnt = 0;
  int fall_through_mode = 0;
  int n = 127;
  int m = 127;

  always #10 clk_sys_i = ~clk_sys_i;

  fofp_ctrl_model ctl (
    .clk_sys_i,
    .master_reset_n_o(master_reset_n_i),
    .partial_reset_n_o(partial_reset_n_i),
    .offset_load_select_n_o(offset_load_select_n_i),
    .write_enable_n_o(write_enable_n_i),
    .read_enable_n_o(read_enable_n_i),
    .shift_enable_n_o(shift_enable_n_i),
    .serial_offset_in_o(serial_offset_in_i),
    .fall_through_mode_o(fall_through_mode_i),
    .data_inputs_o(data_inputs_i)
  );
  fofp_flag_offset #(.DEPTH(D)) dut (
    .clk_sys_i, .rst_i, .master_reset_n_i, .partial_reset_n_i,
    .offset_load_select_n_i, .write_enable_n_i, .read_enable_n_i,
    .shift_enable_n_i, .serial_offset_in_i, .fall_through_mode_i,
    .data_inputs_i, .data_outputs_o, .full_flag_n_o, .empty_flag_n_o,
    .input_ready_n_o, .output_ready_n_o, .half_full_flag_n_o,
    .almost_full_flag_n_o, .almost_empty_flag_n_o, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  task automatic finish_test();
    $display("Comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk_word(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hang();
    num_errors++;
    $display("Error bus answer expected 1 seen 0");
    finish_test();
  endtask
  // Order: full, empty, half, almost full, almost empty, in, out ready
  function automatic logic [6:0] exp_flags(int c);
    exp_flags[6] = !(fall_through_mode == 0 && c == D);
    exp_flags[5] = !(fall_through_mode == 0 && c == 0);
    exp_flags[4] = !(c >= D / 2 + 1 + fall_through_mode);
    exp_flags[3] = !(c >= D + fall_through_mode - m);
    exp_flags[2] = !(c <= n + fall_through_mode);
    exp_flags[1] = (fall_through_mode == 1 && c == D + 1);
    exp_flags[0] = (fall_through_mode == 0 || c == 0);
  endfunction
  task automatic look();
    @(posedge clk_sys_i);
    #1;
    chk_word("flags", 32'(exp_flags(cnt)), 32'({full_flag_n_o,
      empty_flag_n_o, half_full_flag_n_o, almost_full_flag_n_o,
      almost_empty_flag_n_o, input_ready_n_o, output_ready_n_o}));
  endtask
  task automatic step(input logic [3:0] c, input int dc);
    ctl.op(c, 1'b0, 18'($urandom));
    cnt += dc;
    look();
  endtask
  function automatic logic [71:0] parts(logic [16:0] e, f);
    return {10'h0, f[16:9], 9'h0, f[8:0], 10'h0, e[16:9], 9'h0, e[8:0]};
  endfunction
  task automatic wr_ofs(input logic [16:0] e, f);
    logic [71:0] pt;
    pt = parts(e, f);
    for (int p = 0; p < 4; p++) begin
      ctl.op(PWR, 1'b0, pt[18*p +: 18]);
      if (p == 1) begin
        ctl.op(MWR, 1'b0, 18'($urandom));
        cnt++;
      end
    end
  endtask
  // Four reads from part s on, with a memory read in the middle
  task automatic rd_ofs(input int s, input logic [16:0] e, f);
    logic [71:0] pt;
    pt = parts(e, f);
    for (int p = s; p < s + 4; p++) begin
      if (p == s + 2) begin
        ctl.op(MRD, 1'b0, 18'h0);
        cnt = (cnt > 0) ? cnt - 1 : 0;
      end
      ctl.op(PRD, 1'b0, 18'h0);
      @(posedge clk_sys_i);
      #1;
      chk_word("offset part", 32'(pt[18*(p%4) +: 18]),
               32'(data_outputs_o));
    end
  endtask
  task automatic shift_ofs(input logic [16:0] e, f);
    logic [33:0] b;
    b = {f, e};
    for (int p = 0; p < 34; p++) begin
      if (p == 12) ctl.op(NOP, ~b[p], 18'h0);
      if (p == 20) begin
        ctl.op(MWR, 1'b0, 18'($urandom));
        cnt++;
      end
      ctl.op(SHF, b[p], 18'h0);
    end
  endtask
  // Handshakes judged on values settled before the edge that takes them
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int j = 0; j < 50; j++) begin
      @(negedge clk_sys_i);
      aw_ok = s_axi_awready === 1'b1;
      w_ok = s_axi_wready === 1'b1;
      b_ok = s_axi_bvalid === 1'b1;
      resp = s_axi_bresp;
      @(posedge clk_sys_i);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
      if (b_ok) begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask
  task automatic axi_rd(input logic [3:0] a);
    logic ar_ok, r_ok;
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int j = 0; j < 50; j++) begin
      @(negedge clk_sys_i);
      ar_ok = s_axi_arready === 1'b1;
      r_ok = s_axi_rvalid === 1'b1;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk_sys_i);
      if (ar_ok) s_axi_arvalid <= 1'b0;
      if (r_ok) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask
  // Fill until refused, then drain until refused
  task automatic sweep();
    repeat (D + fall_through_mode) step(MWR, 1);
    step(MWR, 0);
    axi_rd(`FOFP_COUNT_ADDR);
    chk_word("count", cnt, rd);
    repeat (D + fall_through_mode) step(MRD, -1);
    step(MRD, 0);
  endtask

  initial begin
    void'($urandom(32'h3BAC33CE));
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    ctl.mreset(1'b0, 1'b0);
    look();
    rd_ofs(0, 17'h7F, 17'h7F);
    n = $urandom_range(100, 1);
    m = $urandom_range(100, 1);
    wr_ofs(n, m);
    rd_ofs(0, n, m);
    repeat (4) @(posedge clk_sys_i);
    sweep();
    repeat (3) step(MWR, 1);
    ctl.op(PRD, 1'b0, 18'h0);
    axi_wr(`FOFP_CTRL_ADDR, 32'h1);
    chk_word("ctrl resp", `FOFP_RESP_OKAY, resp);
    cnt = 0;
    repeat (2) @(posedge clk_sys_i);
    look();
    chk_word("data out", 32'h0, 32'(data_outputs_o));
    rd_ofs(1, n, m);
    ctl.mreset(1'b1, 1'b1);
    fall_through_mode = 1;
    rd_ofs(0, 17'h3FF, 17'h3FF);
    wr_ofs(17'h1, 17'h2);
    rd_ofs(0, 17'h3FF, 17'h3FF);
    n = $urandom_range(100, 1);
    m = $urandom_range(100, 1);
    shift_ofs(n, m);
    rd_ofs(0, n, m);
    repeat (4) @(posedge clk_sys_i);
    axi_rd(`FOFP_STATUS_ADDR);
    chk_word("status", 32'hF, {28'h0, rd[3:0]});
    axi_rd(4'hC);
    chk_word("bad resp", `FOFP_RESP_SLVERR, resp);
    chk_word("bad data", 32'h0, rd);
    sweep();
    repeat (3) step(MWR, 1);
    ctl.preset();
    cnt = 0;
    look();
    chk_word("data out", 32'h0, 32'(data_outputs_o));
    axi_wr(4'hC, 32'h0);
    chk_word("bad wresp", `FOFP_RESP_SLVERR, resp);
    finish_test();
  end
endmodule // test_fofp_flag_offset
